// *** design/flash_status_pkg.sv ***
package flash_status_pkg;

  // serial instruction codes
  localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
  localparam logic [7:0] OP_READ_STATUS_1  = 8'h05;
  localparam logic [7:0] OP_READ_STATUS_2  = 8'h35;
  localparam logic [7:0] OP_READ_STATUS_3  = 8'h15;
  localparam logic [7:0] OP_WRITE_STATUS_1 = 8'h01;
  localparam logic [7:0] OP_WRITE_STATUS_2 = 8'h31;
  localparam logic [7:0] OP_WRITE_STATUS_3 = 8'h11;
  localparam logic [7:0] OP_SUSPEND        = 8'h75;
  localparam logic [7:0] OP_RESUME         = 8'h7a;
  localparam logic [7:0] OP_ENTER_QUAD     = 8'h38;
  localparam logic [7:0] OP_EXIT_QUAD      = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // bit positions inside each status byte
  localparam int SR1_WEL     = 1;
  localparam int SR1_BP_LSB  = 2;
  localparam int SR1_TB      = 5;
  localparam int SR1_SEC     = 6;
  localparam int SR1_SRP_LO  = 7;
  localparam int SR2_SRP_HI  = 0;
  localparam int SR2_QE      = 1;
  localparam int SR2_LB_LSB  = 3;
  localparam int SR2_CMP     = 6;
  localparam int SR2_SUS     = 7;
  localparam int SR3_WPS     = 2;
  localparam int SR3_DRV_LSB = 5;
  localparam int SR3_HOLD    = 7;

  // byte index inside an instruction frame
  localparam logic [1:0] IDX_OPCODE = 2'h0;
  localparam logic [1:0] IDX_FIRST  = 2'h1;
  localparam logic [1:0] IDX_SECOND = 2'h2;
  localparam logic [1:0] IDX_LAST   = 2'h3;
  localparam logic [2:0] BIT_LAST   = 3'h7;

  localparam logic [1:0] SRP_SOFTWARE = 2'h0;
  localparam logic [1:0] SRP_HARDWARE = 2'h1;
  localparam logic [1:0] SRP_LOCKDOWN = 2'h2;
  localparam logic [1:0] SRP_OTP      = 2'h3;

  localparam logic [2:0] BP_NONE       = 3'h0;
  localparam logic [2:0] BP_ALL        = 3'h7;
  localparam logic [2:0] BP_SECTOR_MAX = 3'h4;

  // array measured in 4KB sectors
  localparam int         SECT_W            = 11;
  localparam logic [10:0] ARRAY_SECTORS    = 11'h400;
  localparam logic [10:0] SECTORS_PER_BLOCK = 11'h010;
  localparam int         LOCK_COUNT_DEFAULT = 542;

  typedef enum logic [1:0] {
    DRIVE_FULL,
    DRIVE_THREE_QUARTER,
    DRIVE_HALF,
    DRIVE_QUARTER
  } driveStrength_t;

  typedef struct packed {
    logic [1:0]     srp;
    logic           write_enable_latch;
    logic [2:0]     bp;
    logic           tb;
    logic           sec;
    logic           cmp;
    logic [2:0]     lb;
    logic           qe;
    logic           suspend_flag;
    logic           protect_scheme_sel;
    driveStrength_t drv;
    logic           holdRst;
  } statusBits_t;

  localparam statusBits_t STATUS_FACTORY = '0;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] data;
    logic [1:0] idx;
  } cmdEvent_t;

  typedef struct packed {
    logic              valid;
    logic [SECT_W-1:0] lo;
    logic [SECT_W-1:0] hi;
  } protectWin_t;

endpackage

// *** design/flash_status_protect_config.sv ***
`timescale 1ns/1ps
// Function
// R1 - SEC=1 sectors of 4KB, SEC=0 64KB blocks
// R2 - complement bit inverts chosen protected region
// R3 - status-protect pair sits at S8 and S7
// R4 - pair 00 ignores pin, WRITE_ENABLE_LATCH gates writes
// R5 - pair 01 with pin low rejects writes
// R6 - pair 01 with pin high needs WRITE_ENABLE_LATCH
// R7 - pair 10 locks until power cycle
// R8 - pair 11 refuses status writes forever
// R9 - suspend flag set 75h, cleared 7Ah/power
// R10 - security lock bits set once, never clear
// R11 - quad enable turns protect/hold into data
// R12 - enter quad mode ignored unless QE set
// R13 - quad mode keeps quad enable at one
// R14 - scheme bit picks region or lock bits
// R15 - all lock bits forced locked on reset
// R16 - drive bits encode 100/75/50/25 percent
// R17 - QE=0 pin is hold or reset
// R18 - QE=1 disables hold and reset functions
// R19 - reserved bits ignored on write
// R20 - host never sets QE with tied pins
// R21 - top/bottom bit places region top or bottom
// R22 - write enable latch set and cleared
// R23 - block-protect bits at S4..S2, default zero
// R24 - reserved bits read back as zero
// R25 - rejected write still clears write enable
module flash_status_protect_config #(
  parameter int LOCK_COUNT = flash_status_pkg::LOCK_COUNT_DEFAULT
) (
  // system
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  // serial link
  input  wire logic                          linkClk,
  input  wire logic                          csN,
  input  wire logic                          dataLine0,
  output logic                               dataLine1,
  output logic                               dataLine1Oe,
  // shared control pins
  input  wire logic                          dataLine2,
  input  wire logic                          dataLine3,
  input  wire logic                          supplyRestart,
  // configuration seen by the array
  output flash_status_pkg::statusBits_t      status,
  output flash_status_pkg::protectWin_t      protectWindow,
  output logic [LOCK_COUNT-1:0]              blockLocks,
  output logic                               quadCommandMode,
  output logic                               holdFunction,
  output logic                               resetFunction
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic [1:0] rstPipeQ;
  logic       rstSyncN;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstPipeQ <= '0;
    end else begin
      rstPipeQ <= {rstPipeQ[0], 1'h1};
    end
  end
  assign rstSyncN = rstPipeQ[1];

  // bit 0 protect pin, 1 hold/reset pin, 2 supply restart
  logic [2:0] pinMetaQ;
  logic [2:0] pinSyncQ;
  logic       restartPrevQ;
  logic       restartEdge;

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pinMetaQ     <= 3'h3;
      pinSyncQ     <= 3'h3;
      restartPrevQ <= '0;
    end else begin
      pinMetaQ     <= {supplyRestart, dataLine3, dataLine2};
      pinSyncQ     <= pinMetaQ;
      restartPrevQ <= pinSyncQ[2];
    end
  end
  assign restartEdge = pinSyncQ[2] & ~restartPrevQ;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: frame shifter

  flash_status_pkg::statusBits_t statusQ;
  flash_status_pkg::cmdEvent_t   evPayloadQ;
  logic        evToggleQ;
  logic        holdFunctionQ;
  logic [1:0]  holdCfgQ;
  logic [1:0]  holdPinQ;
  logic        paused;
  logic [2:0]  bitCntQ;
  logic [1:0]  byteIdxQ;
  logic [7:0]  shiftInQ;
  logic [7:0]  opcodeQ;
  logic [7:0]  newByte;
  logic        byteDone;
  logic        loadPulseQ;
  logic [1:0]  readSelQ;
  logic        isRead;

  always_ff @(posedge linkClk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      holdCfgQ <= '0;
      holdPinQ <= 2'h3;
    end else begin
      holdCfgQ <= {holdCfgQ[0], holdFunctionQ};
      holdPinQ <= {holdPinQ[0], dataLine3};
    end
  end
  // hold freezes the shifter mid-frame
  assign paused   = holdCfgQ[1] & ~holdPinQ[1];  // see R17
  assign newByte  = {shiftInQ[6:0], dataLine0};
  assign byteDone = (bitCntQ == flash_status_pkg::BIT_LAST) & ~paused;
  assign isRead   = (newByte == flash_status_pkg::OP_READ_STATUS_1) |
                    (newByte == flash_status_pkg::OP_READ_STATUS_2) |
                    (newByte == flash_status_pkg::OP_READ_STATUS_3);

  // chip select high ends the frame without needing a link edge
  always_ff @(posedge linkClk or posedge csN) begin
    if (csN) begin
      bitCntQ    <= '0;
      byteIdxQ   <= flash_status_pkg::IDX_OPCODE;
      shiftInQ   <= '0;
      opcodeQ    <= '0;
      loadPulseQ <= '0;
      readSelQ   <= '0;
    end else begin
      loadPulseQ <= byteDone & (byteIdxQ == flash_status_pkg::IDX_OPCODE) & isRead;
      if (!paused) begin
        shiftInQ <= newByte;
        bitCntQ  <= bitCntQ + 3'h1;
      end
      if (byteDone) begin
        if (byteIdxQ != flash_status_pkg::IDX_LAST) begin
          byteIdxQ <= byteIdxQ + 2'h1;
        end
        if (byteIdxQ == flash_status_pkg::IDX_OPCODE) begin
          opcodeQ  <= newByte;
          readSelQ <= (newByte == flash_status_pkg::OP_READ_STATUS_1) ? 2'h0 :
                      (newByte == flash_status_pkg::OP_READ_STATUS_2) ? 2'h1 : 2'h2;
        end
      end
    end
  end

  // every completed byte becomes one event; payload holds until the next byte
  always_ff @(posedge linkClk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      evToggleQ  <= '0;
      evPayloadQ <= '0;
    end else if (byteDone) begin
      evToggleQ         <= ~evToggleQ;
      evPayloadQ.opcode <= (byteIdxQ == flash_status_pkg::IDX_OPCODE) ? newByte : opcodeQ;
      evPayloadQ.data   <= newByte;
      evPayloadQ.idx    <= byteIdxQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status snapshot handshake toward the link

  logic        snapReqQ;
  logic [23:0] snapDataQ;
  logic [1:0]  snapReqLinkQ;
  logic        snapAckQ;
  logic [23:0] snapCapQ;
  logic [1:0]  ackSysQ;
  logic [7:0]  outShiftQ;
  logic        outEnQ;

  always_ff @(posedge linkClk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      snapReqLinkQ <= '0;
      snapAckQ     <= '0;
      snapCapQ     <= '0;
    end else begin
      snapReqLinkQ <= {snapReqLinkQ[0], snapReqQ};
      if (snapReqLinkQ[1] != snapAckQ) begin
        snapCapQ <= snapDataQ;
        snapAckQ <= snapReqLinkQ[1];
      end
    end
  end

  // output changes on the falling edge; the byte repeats while clocks continue
  always_ff @(negedge linkClk or posedge csN) begin
    if (csN) begin
      outShiftQ <= '0;
      outEnQ    <= '0;
    end else if (loadPulseQ) begin
      outShiftQ <= snapCapQ[readSelQ*8 +: 8];
      outEnQ    <= 1'h1;
    end else if (outEnQ && !paused) begin
      outShiftQ <= {outShiftQ[6:0], outShiftQ[7]};
    end
  end
  assign dataLine1   = outShiftQ[7];
  assign dataLine1Oe = outEnQ;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: event capture

  logic [2:0] evSyncQ;
  logic       evFire;
  flash_status_pkg::cmdEvent_t cmd;

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      evSyncQ <= '0;
      ackSysQ <= '0;
    end else begin
      evSyncQ <= {evSyncQ[1:0], evToggleQ};
      ackSysQ <= {ackSysQ[0], snapAckQ};
    end
  end
  assign evFire = evSyncQ[2] ^ evSyncQ[1];
  // payload is stable for a whole byte time, far longer than the sync delay
  assign cmd = evPayloadQ;

  ////////////////////////////////////////////////////////////////////////////
  // status write gating and register update

  flash_status_pkg::statusBits_t statusD;
  logic       quadModeQ;
  logic       quadModeD;
  logic       grantQ;
  logic       grantD;
  logic       wpEffective;
  logic       srpAllow;
  logic       resetPinLow;
  logic       isWrite;
  logic       writeOk;
  logic [1:0] target;

  assign wpEffective = statusQ.qe | pinSyncQ[0];  // see R11
  assign resetPinLow = ~statusQ.qe & statusQ.holdRst & ~pinSyncQ[1];  // see R17
  assign isWrite = (cmd.opcode == flash_status_pkg::OP_WRITE_STATUS_1) |
                   (cmd.opcode == flash_status_pkg::OP_WRITE_STATUS_2) |
                   (cmd.opcode == flash_status_pkg::OP_WRITE_STATUS_3);

  always_comb begin
    unique case (statusQ.srp)
      flash_status_pkg::SRP_SOFTWARE: srpAllow = 1'h1;         // see R4
      flash_status_pkg::SRP_HARDWARE: srpAllow = wpEffective;  // see R5 see R6
      flash_status_pkg::SRP_LOCKDOWN: srpAllow = 1'h0;         // see R7
      flash_status_pkg::SRP_OTP:      srpAllow = 1'h0;         // see R8
    endcase
  end

  // second data byte of a two-byte write reuses the first byte's verdict
  assign writeOk = (cmd.idx == flash_status_pkg::IDX_FIRST) ? (statusQ.write_enable_latch & srpAllow) : grantQ;

  always_comb begin
    if (cmd.opcode == flash_status_pkg::OP_WRITE_STATUS_1) begin
      target = (cmd.idx == flash_status_pkg::IDX_FIRST)  ? 2'h1 :
               (cmd.idx == flash_status_pkg::IDX_SECOND) ? 2'h2 : 2'h0;
    end else if (cmd.idx != flash_status_pkg::IDX_FIRST) begin
      target = 2'h0;
    end else if (cmd.opcode == flash_status_pkg::OP_WRITE_STATUS_2) begin
      target = 2'h2;
    end else if (cmd.opcode == flash_status_pkg::OP_WRITE_STATUS_3) begin
      target = 2'h3;
    end else begin
      target = 2'h0;
    end
  end

  always_comb begin
    statusD   = statusQ;
    quadModeD = quadModeQ;
    grantD    = grantQ;
    if (restartEdge || resetPinLow) begin
      statusD.write_enable_latch = 1'h0;  // see R22
      statusD.suspend_flag = 1'h0;  // see R9
      quadModeD   = 1'h0;
      if (restartEdge && statusQ.srp == flash_status_pkg::SRP_LOCKDOWN) begin
        statusD.srp = flash_status_pkg::SRP_SOFTWARE;  // see R7
      end
    end else if (evFire && cmd.idx == flash_status_pkg::IDX_OPCODE) begin
      unique case (cmd.opcode)
        flash_status_pkg::OP_WRITE_ENABLE:  statusD.write_enable_latch = 1'h1;  // see R22
        flash_status_pkg::OP_WRITE_DISABLE: statusD.write_enable_latch = 1'h0;  // see R22
        flash_status_pkg::OP_SUSPEND:       statusD.suspend_flag = 1'h1;  // see R9
        flash_status_pkg::OP_RESUME:        statusD.suspend_flag = 1'h0;  // see R9
        flash_status_pkg::OP_ENTER_QUAD:    quadModeD = quadModeQ | statusQ.qe;  // see R12
        flash_status_pkg::OP_EXIT_QUAD:     quadModeD = 1'h0;
        default: ;
      endcase
    end else if (evFire && isWrite) begin
      if (cmd.idx == flash_status_pkg::IDX_FIRST) begin
        grantD      = writeOk;
        statusD.write_enable_latch = 1'h0;  // see R25 see R22
      end
      // reserved positions are simply never copied
      if (writeOk) begin  // see R19
        unique case (target)
          2'h1: begin
            statusD.bp     = cmd.data[flash_status_pkg::SR1_BP_LSB +: 3];  // see R23
            statusD.tb     = cmd.data[flash_status_pkg::SR1_TB];           // see R21
            statusD.sec    = cmd.data[flash_status_pkg::SR1_SEC];          // see R1
            statusD.srp[0] = cmd.data[flash_status_pkg::SR1_SRP_LO];       // see R3
          end
          2'h2: begin
            statusD.srp[1] = cmd.data[flash_status_pkg::SR2_SRP_HI];       // see R3
            statusD.qe     = quadModeQ | cmd.data[flash_status_pkg::SR2_QE];  // see R13
            statusD.lb     = statusQ.lb | cmd.data[flash_status_pkg::SR2_LB_LSB +: 3];  // see R10
            statusD.cmp    = cmd.data[flash_status_pkg::SR2_CMP];          // see R2
          end
          2'h3: begin
            statusD.protect_scheme_sel     = cmd.data[flash_status_pkg::SR3_WPS];         // see R14
            statusD.drv     = flash_status_pkg::driveStrength_t'(cmd.data[flash_status_pkg::SR3_DRV_LSB +: 2]);
            statusD.holdRst = cmd.data[flash_status_pkg::SR3_HOLD];        // see R17
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      statusQ   <= flash_status_pkg::STATUS_FACTORY;
      quadModeQ <= '0;
      grantQ    <= '0;
    end else begin
      statusQ   <= statusD;
      quadModeQ <= quadModeD;
      grantQ    <= grantD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // derived outputs

  function automatic flash_status_pkg::protectWin_t regionOf(flash_status_pkg::statusBits_t s);
    flash_status_pkg::protectWin_t w;
    logic [2:0]  k;
    logic [10:0] len;
    w.valid = ~s.protect_scheme_sel;  // see R14
    k = (s.sec && s.bp > flash_status_pkg::BP_SECTOR_MAX) ? flash_status_pkg::BP_SECTOR_MAX : s.bp;
    len = s.sec ? (11'h001 << (k - 3'h1)) : (flash_status_pkg::SECTORS_PER_BLOCK << (k - 3'h1));  // see R1
    if (s.bp == flash_status_pkg::BP_NONE) begin
      w.lo = '0;
      w.hi = '0;
    end else if (s.bp == flash_status_pkg::BP_ALL) begin
      w.lo = '0;
      w.hi = flash_status_pkg::ARRAY_SECTORS;
    end else if (s.tb) begin
      w.lo = '0;
      w.hi = len;  // see R21
    end else begin
      w.lo = flash_status_pkg::ARRAY_SECTORS - len;
      w.hi = flash_status_pkg::ARRAY_SECTORS;
    end
    if (s.cmp) begin  // see R2
      if (w.lo == w.hi) begin
        w.lo = '0;
        w.hi = flash_status_pkg::ARRAY_SECTORS;
      end else if (w.lo == '0 && w.hi == flash_status_pkg::ARRAY_SECTORS) begin
        w.hi = '0;
      end else if (w.lo == '0) begin
        w.lo = w.hi;
        w.hi = flash_status_pkg::ARRAY_SECTORS;
      end else begin
        w.hi = w.lo;
        w.lo = '0;
      end
    end
    return w;
  endfunction

  flash_status_pkg::protectWin_t protectQ;
  logic [LOCK_COUNT-1:0]         lockQ;
  logic                          resetFunctionQ;

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      protectQ       <= '0;
      lockQ          <= '1;
      holdFunctionQ  <= '0;
      resetFunctionQ <= '0;
    end else begin
      protectQ       <= regionOf(statusQ);
      holdFunctionQ  <= ~statusQ.qe & ~statusQ.holdRst;  // see R17 see R18
      resetFunctionQ <= ~statusQ.qe & statusQ.holdRst;   // see R18
      if (restartEdge || resetPinLow) begin
        lockQ <= '1;  // see R15
      end
    end
  end

  // snapshot refresh runs continuously; a read may lag a write by a few cycles
  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      snapReqQ  <= '0;
      snapDataQ <= '0;
    end else if (ackSysQ[1] == snapReqQ) begin
      snapReqQ  <= ~snapReqQ;
      snapDataQ <= '0;  // see R24
      snapDataQ[flash_status_pkg::SR1_WEL]             <= statusQ.write_enable_latch;
      snapDataQ[flash_status_pkg::SR1_BP_LSB +: 3]     <= statusQ.bp;
      snapDataQ[flash_status_pkg::SR1_TB]              <= statusQ.tb;
      snapDataQ[flash_status_pkg::SR1_SEC]             <= statusQ.sec;
      snapDataQ[flash_status_pkg::SR1_SRP_LO]          <= statusQ.srp[0];
      snapDataQ[8 + flash_status_pkg::SR2_SRP_HI]      <= statusQ.srp[1];
      snapDataQ[8 + flash_status_pkg::SR2_QE]          <= statusQ.qe;
      snapDataQ[8 + flash_status_pkg::SR2_LB_LSB +: 3] <= statusQ.lb;
      snapDataQ[8 + flash_status_pkg::SR2_CMP]         <= statusQ.cmp;
      snapDataQ[8 + flash_status_pkg::SR2_SUS]         <= statusQ.suspend_flag;
      snapDataQ[16 + flash_status_pkg::SR3_WPS]        <= statusQ.protect_scheme_sel;
      snapDataQ[16 + flash_status_pkg::SR3_DRV_LSB +: 2] <= statusQ.drv;  // see R16
      snapDataQ[16 + flash_status_pkg::SR3_HOLD]       <= statusQ.holdRst;
    end
  end

  assign status          = statusQ;
  assign protectWindow   = protectQ;
  assign blockLocks      = lockQ;
  assign quadCommandMode = quadModeQ;
  assign holdFunction    = holdFunctionQ;
  assign resetFunction   = resetFunctionQ;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence sFirstWrite;
    evFire && isWrite && cmd.idx == flash_status_pkg::IDX_FIRST && !restartEdge && !resetPinLow;
  endsequence

  sequence sOpcode(logic [7:0] op);
    evFire && cmd.idx == flash_status_pkg::IDX_OPCODE && cmd.opcode == op && !restartEdge && !resetPinLow;
  endsequence

  a_wel_write_clear: assert property (@(posedge clock) disable iff (!rstSyncN)  // see R25
    sFirstWrite |=> !statusQ.write_enable_latch) else $error("write enable survived a status write");
  a_otp_pair_fixed: assert property (@(posedge clock) disable iff (!rstSyncN)  // see R8
    statusQ.srp == flash_status_pkg::SRP_OTP |=> statusQ.srp == flash_status_pkg::SRP_OTP)
    else $error("one-time protect pair changed");
  a_hw_protect_block: assert property (@(posedge clock) disable iff (!rstSyncN)  // see R5
    sFirstWrite ##0 (statusQ.srp == flash_status_pkg::SRP_HARDWARE && !wpEffective)
    |=> $stable(statusQ.bp) && $stable(statusQ.tb) && $stable(statusQ.sec)) else $error("write passed low protect pin");
  a_sw_write_take: assert property (@(posedge clock) disable iff (!rstSyncN)  // see R4
    sFirstWrite ##0 (statusQ.srp == flash_status_pkg::SRP_SOFTWARE && statusQ.write_enable_latch &&
    cmd.opcode == flash_status_pkg::OP_WRITE_STATUS_1)
    |=> statusQ.bp == $past(cmd.data[flash_status_pkg::SR1_BP_LSB +: 3])) else $error("granted write not stored");
  a_lock_bits_sticky: assert property (@(posedge clock) disable iff (!rstSyncN)  // see R10
    ##1 (statusQ.lb & $past(statusQ.lb)) == $past(statusQ.lb)) else $error("security lock bit cleared");
  a_quad_enter_gate: assert property (@(posedge clock) disable iff (!rstSyncN)  // see R12
    sOpcode(flash_status_pkg::OP_ENTER_QUAD) ##0 (!quadModeQ && !statusQ.qe) |=> !quadModeQ)
    else $error("quad mode entered without quad enable");
  a_quad_keeps_qe: assert property (@(posedge clock) disable iff (!rstSyncN)  // see R13
    quadModeQ |-> statusQ.qe ##1 (!quadModeQ || statusQ.qe)) else $error("quad enable dropped in quad mode");
  a_suspend_flag: assert property (@(posedge clock) disable iff (!rstSyncN)  // see R9
    sOpcode(flash_status_pkg::OP_SUSPEND) |=> statusQ.suspend_flag)
    else $error("suspend flag not set");
  a_lockdown_restart: assert property (@(posedge clock) disable iff (!rstSyncN)  // see R7
    restartEdge && statusQ.srp == flash_status_pkg::SRP_LOCKDOWN |=> statusQ.srp == flash_status_pkg::SRP_SOFTWARE)
    else $error("lock-down pair not released by power cycle");
  a_pin_function_qe: assert property (@(posedge clock) disable iff (!rstSyncN)  // see R18
    statusQ.qe [*2] |-> !holdFunctionQ && !resetFunctionQ) else $error("hold or reset active with quad enable");
  a_scheme_select: assert property (@(posedge clock) disable iff (!rstSyncN)  // see R14
    statusQ.protect_scheme_sel |=> !protectQ.valid) else $error("region window valid under lock-bit scheme");
  a_reset_locks_all: assert property (@(posedge clock) disable iff (!rstSyncN)  // see R15
    restartEdge |=> &lockQ) else $error("lock bits not forced after reset");

endmodule

// *** bench/host_spi_model.sv ***
`timescale 1ns/1ps
module host_spi_model (
  // serial link
  output logic      linkClk,
  output logic      csN,
  output logic      dataLine0,
  input  wire logic dataLine1
);
  initial begin
    {linkClk, csN, dataLine0} = 3'h2;
  end
  // clock stands still between frames; data idles at the inverse of its last bit
  task automatic frame(input logic [23:0] v, input int n, output logic [7:0] rd);
    csN = 1'b0;
    for (int i = 0; i < n; i++) begin
      dataLine0 = v[23-i];
      #16 linkClk = 1'b1;
      if (i > 7 && i < 16) rd = {rd[6:0], dataLine1};
      #16 linkClk = 1'b0;
    end
    #16 csN = 1'b1;
    dataLine0 = ~dataLine0;
  endtask
endmodule

// *** bench/flash_status_protect_config_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin failCount++; $display("Error t=%0t got %h exp %h", $time, a, e); end end
module flash_status_protect_config_tb_top;
  logic clock = 1'b0, rst_n = 1'b0, supplyRestart = 1'b0, dataLine2 = 1'b1, dataLine3 = 1'b1;
  wire  linkClk, csN, dataLine0, dataLine1, dataLine1Oe;
  logic quadCommandMode, holdFunction, resetFunction;
  logic [7:0] rd;
  logic [flash_status_pkg::LOCK_COUNT_DEFAULT-1:0] blockLocks;
  flash_status_pkg::statusBits_t status;
  flash_status_pkg::protectWin_t protectWindow;
  int   failCount = 0, nChecks = 0;
  logic [15:0] wv[4] = '{16'h1c00, 16'h4400, 16'h6400, 16'h0440};
  logic [21:0] ex[4] = '{22'h00_0400, {11'h3ff, 11'h400}, 22'h00_0001, {11'h000, 11'h3f0}};
  always #12.5 clock = ~clock;
  flash_status_protect_config i_flash_status_protect_config (.clock(clock), .rst_n(rst_n), .linkClk(linkClk),
    .csN(csN), .dataLine0(dataLine0), .dataLine1(dataLine1), .dataLine1Oe(dataLine1Oe), .dataLine2(dataLine2),
    .dataLine3(dataLine3), .supplyRestart(supplyRestart), .status(status), .protectWindow(protectWindow),
    .blockLocks(blockLocks), .quadCommandMode(quadCommandMode), .holdFunction(holdFunction),
    .resetFunction(resetFunction));
  host_spi_model i_host_spi_model (.linkClk(linkClk), .csN(csN), .dataLine0(dataLine0), .dataLine1(dataLine1));
  //////////////////////////////////////////////////////////////////////////////
  // 1 us after each frame lets the snapshot of the status settle
  task automatic cmd(input logic [23:0] v, input int n);
    i_host_spi_model.frame(v, n, rd);
    repeat (40) @(posedge clock);
  endtask
  task automatic wr(input logic [23:0] v, input int n);
    cmd(24'h06_0000, 8);
    cmd(v, n);
  endtask
  task automatic pulse();
    @(posedge clock) #1 supplyRestart = 1'b1;
    repeat (4) @(posedge clock);
    #1 supplyRestart = 1'b0;
    repeat (40) @(posedge clock);
  endtask
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #1ms failCount++;
    wrapUp();
  end
  initial begin
    repeat (12) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge clock);
    `CHK(status, flash_status_pkg::STATUS_FACTORY)
    `CHK({&blockLocks, holdFunction, resetFunction}, 3'h6)
    cmd(24'h01_1c00, 24);
    `CHK(status.bp, 3'h0)
    cmd(24'h06_0000, 8);
    `CHK(status.write_enable_latch, 1'b1)
    cmd(24'h04_0000, 8);
    `CHK(status.write_enable_latch, 1'b0)
    for (int k = 0; k < 4; k++) begin
      wr({8'h01, wv[k]}, 24);
      `CHK({protectWindow.lo, protectWindow.hi}, ex[k])
    end
    $display("test reset and region done");
    wr(24'h01_8000, 24);
    `CHK(status.srp, 2'h1)
    @(posedge clock) #1 dataLine2 = 1'b0;
    wr(24'h01_1c00, 24);
    `CHK({status.bp, status.write_enable_latch}, 4'h0)
    @(posedge clock) #1 dataLine2 = 1'b1;
    wr(24'h01_1c00, 24);
    cmd(24'h05_0000, 17);
    `CHK(rd, 8'h1c)
    wr(24'h01_1c01, 24);
    wr(24'h01_0000, 24);
    `CHK({status.srp, status.bp}, 5'h17)
    pulse();
    `CHK({status.srp, status.bp, status.write_enable_latch}, 6'h0e)
    $display("test protect done");
    cmd(24'h75_0000, 8);
    `CHK(status.suspend_flag, 1'b1)
    cmd(24'h7a_0000, 8);
    `CHK(status.suspend_flag, 1'b0)
    wr(24'h31_0800, 16);
    wr(24'h31_0000, 16);
    `CHK(status.lb, 3'h1)
    cmd(24'h38_0000, 8);
    `CHK(quadCommandMode, 1'b0)
    wr(24'h31_0200, 16);
    `CHK({holdFunction, resetFunction}, 2'h0)
    cmd(24'h38_0000, 8);
    wr(24'h31_0000, 16);
    `CHK({quadCommandMode, status.qe}, 2'h3)
    cmd(24'hff_0000, 8);
    wr(24'h31_0000, 16);
    $display("test suspend and quad done");
    for (int d = 0; d < 4; d++) begin
      wr({8'h11, 1'b0, d[1:0], 5'h1f, 8'h00}, 16);
      `CHK(status.drv, d[1:0])
    end
    cmd(24'h15_0000, 17);
    `CHK({rd, protectWindow.valid}, 9'h0c8)
    wr(24'h11_8000, 16);
    `CHK({holdFunction, resetFunction}, 2'h1)
    wr(24'h01_8001, 24);
    wr(24'h01_0000, 24);
    pulse();
    `CHK(status.srp, 2'h3)
    $display("test config done");
    wrapUp();
  end
endmodule
